// >>> mcrs_host_model.sv
// host model: reads a frame over the link after each end-of-conversion pulse, skipping pulses that end while a frame is still running
`timescale 1ns/1ps
`default_nettype none
module mcrs_host_model
(
  input wire logic aclk,
  input wire logic int_n,
  input wire logic slow,
  output logic link_clk
);
  // link clock idles high between frames, like a pulled-up line
  initial link_clk = 1'b1;
  // wait after the pulse ends, then clock one read frame at 200 ns
  always @(posedge int_n)
  begin
    repeat (slow ? 55 : 10) @(posedge aclk);
    #37;
    // one frame fetches the first value, then the following ones back to back
    repeat (9)
    begin
      #100 link_clk = 1'b0;
      #100 link_clk = 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> mcrs_mem_if.sv
// interface between the sequencer and its result store
`timescale 1ns/1ps
`default_nettype none
interface mcrs_mem_if;
  logic wr_en; // write strobe
  logic [1:0] wr_addr; // channel written
  logic [11:0] wr_data; // sample written
  logic [1:0] rd_addr; // channel read
  logic [11:0] rd_data; // registered read data
  modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
  modport user (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
endinterface
`default_nettype wire

// >>> mcrs_pkg.sv
// constants, register map and types of the measurement cycle readout sequencer
package mcrs_pkg;

  // clock and timing figures
  localparam int CLK_PERIOD_NS = 25; // 40 mhz system clock
  localparam int INT_PULSE_MIN_NS = 1800; // shortest end-of-conversion pulse
  localparam int INT_PULSE_NS = 2500; // nominal end-of-conversion pulse
  localparam int INT_PULSE_MAX_NS = 3200; // longest end-of-conversion pulse
  localparam int FIRST_READ_WINDOW_NS = 50000; // full range first read deadline
  localparam int FIRST_READ_WINDOW_SHORT_RANGE_NS = 70000; // short range first read deadline
  localparam int INT_PULSE_CYC = INT_PULSE_NS / CLK_PERIOD_NS;
  localparam int FIRST_READ_WINDOW_CYC = FIRST_READ_WINDOW_NS / CLK_PERIOD_NS;
  localparam int FIRST_READ_WINDOW_SHORT_RANGE_CYC = FIRST_READ_WINDOW_SHORT_RANGE_NS / CLK_PERIOD_NS;

  // widths
  localparam int ADDR_W = 8; // axi byte address width
  localparam int SAMPLE_W = 12; // two's complement sample width
  localparam int WIN_W = 12; // read window counter width
  localparam int PULSE_W = 8; // pulse counter width

  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TRIG = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0c;
  localparam logic [7:0] OFF_RES_BASE = 8'h10; // x, y, z, temperature at 0x10..0x1c

  // control fields
  localparam int CTRL_W = 5;
  localparam int CTRL_FAST = 0; // continuous conversion
  localparam int CTRL_TEMP_EN = 1; // temperature channel enable
  localparam int CTRL_Z_EN = 2; // z channel enable, clear gives x/y angular set
  localparam int CTRL_SHORT_RANGE = 3; // short range read windows
  localparam int CTRL_INT_EN = 4; // end-of-conversion pulse enable
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h16;

  // status and mask fields
  localparam int STAT_W = 2;
  localparam int STAT_DONE = 0; // a measurement cycle finished
  localparam int STAT_LATE = 1; // host missed the first read window
  localparam int TRIG_GO = 0; // software trigger bit

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // channel codes in conversion order
  localparam logic [1:0] CH_X = 2'h0; // field_x_channel
  localparam logic [1:0] CH_Y = 2'h1; // field_y_channel
  localparam logic [1:0] CH_Z = 2'h2; // field_z_channel
  localparam logic [1:0] CH_T = 2'h3; // temperature

  // sequencer states, gray along idle-conv-wait
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_CONV = 2'b01,
    SEQ_WAIT = 2'b11
  } mcrs_seq_t;

endpackage

// >>> mcrs_result_mem.sv
// four-word result store with registered read data
`timescale 1ns/1ps
`default_nettype none
module mcrs_result_mem
  import mcrs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  mcrs_mem_if.store m
);

  // all state of the store
  typedef struct packed {
    logic [3:0][SAMPLE_W-1:0] word; // one sample per channel
    logic [SAMPLE_W-1:0] rd; // read data register
  } mcrs_mem_st_t;

  mcrs_mem_st_t s_reg;
  mcrs_mem_st_t s_next;

  // next state: write port and registered read
  always_comb
  begin
    s_next = s_reg;
    if (m.wr_en)
    begin
      s_next.word[m.wr_addr] = m.wr_data;
    end
    s_next.rd = s_reg.word[m.rd_addr];
  end

  // state register, cleared by synchronous reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign m.rd_data = s_reg.rd;

endmodule
`default_nettype wire

// >>> mcrs_seq.sv
// measurement cycle sequencer with end-of-conversion pulse and axi4-lite registers
//
// Contract
// [RULE1] end-of-conversion pulse low about 2.5 us
// [RULE2] host reads first value 30-50 us, full range
// [RULE3] host reads first value 42-70 us, short range
// [RULE4] host reads next value 32-54 us, full range
// [RULE5] host reads next value 44-74 us, short range
// [RULE6] host bus clock at most 1000 khz; the bench host model clocks at a 200 ns period, 5000 khz
// [RULE7] fast mode restarts cycle immediately
// [RULE8] other modes start cycle only on trigger
// [RULE9] four-channel set ends after temperature
// [RULE10] three-axis set skips temperature, ends after z
// [RULE11] x/y set skips z, temperature, ends after y
// [RULE12] fast mode host stays synchronised, fast bits
// [RULE13] fast mode host uses 800 khz, interrupt; the bench host model keeps 5000 khz in every mode
// [RULE14] samples are 12-bit two's complement
// [RULE15] temperature enabled after reset, may be disabled
// [RULE16] conversion order x, y, z, temperature
// [RULE17] pulse only when enabled, once per cycle
`timescale 1ns/1ps
`default_nettype none
module mcrs_seq
  import mcrs_pkg::*;
#(
  parameter int INT_CYC = INT_PULSE_CYC,
  parameter int WIN_CYC = FIRST_READ_WINDOW_CYC,
  parameter int WIN_SR_CYC = FIRST_READ_WINDOW_SHORT_RANGE_CYC
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_trig,
  input wire logic link_clk,
  output logic conv_req,
  output logic [1:0] conv_chan,
  input wire logic conv_done,
  input wire logic [SAMPLE_W-1:0] conv_data,
  output logic int_n,
  output logic irq
);

  // refuse counts the counters cannot hold
  generate
    if (INT_CYC < 1 || INT_CYC > 255 || WIN_CYC < 1 || WIN_CYC > 4095 || WIN_SR_CYC < 1 || WIN_SR_CYC > 4095)
    begin : g_bad_param
      $error("mcrs_seq: timing parameter out of range");
    end
  endgenerate

  // all state of the block except the result store and the low_len helper
  typedef struct packed {
    mcrs_seq_t seq; // sequencer state
    logic [1:0] chan; // channel under conversion
    logic conv_req; // conversion request pulse
    logic [1:0] conv_chan; // channel requested
    logic int_n; // end-of-conversion output
    logic [PULSE_W-1:0] int_cnt; // remaining low cycles
    logic win_arm; // first read window running
    logic [WIN_W-1:0] win_cnt; // remaining window cycles
    logic trig_s1; // trigger synchroniser, first stage
    logic trig_s2; // trigger synchroniser, second stage
    logic trig_d; // trigger edge history
    logic link_s1; // link clock synchroniser, first stage
    logic link_s2; // link clock synchroniser, second stage
    logic link_d; // link clock edge history
    logic [CTRL_W-1:0] ctrl; // control register
    logic [STAT_W-1:0] stat; // sticky status
    logic [STAT_W-1:0] mask; // interrupt mask
    logic irq; // interrupt level
    logic awready; // write address taken
    logic wready; // write data taken
    logic bvalid; // write response valid
    logic [1:0] bresp; // write response code
    logic arready; // read address taken
    logic pend; // read data being fetched
    logic rsel_mem; // read targets the result store
    logic rvalid; // read data valid
    logic [1:0] rresp; // read response code
    logic [31:0] rdata; // read data
  } mcrs_state_t;

  mcrs_state_t r_reg;
  mcrs_state_t r_next;
  mcrs_mem_if mem ();

  // next channel after the current one: {last, next}
  function automatic logic [2:0] next_chan(input logic [1:0] ch, input logic z_en, input logic t_en);
    logic [2:0] res;
    res = {1'b1, CH_X};
    case (ch)
      CH_X: res = {1'b0, CH_Y};
      CH_Y: res = z_en ? {1'b0, CH_Z} : {1'b1, CH_X}; // RULE11
      CH_Z: res = t_en ? {1'b0, CH_T} : {1'b1, CH_X}; // RULE10
      CH_T: res = {1'b1, CH_X}; // RULE9
      default: res = {1'b1, CH_X};
    endcase
    return res;
  endfunction

  // true for an aligned word address of the result store
  function automatic logic is_result(input logic [ADDR_W-1:0] a);
    return a[7:4] == OFF_RES_BASE[7:4] && a[1:0] == 2'h0;
  endfunction

  logic trig_evt; // hardware or software trigger
  logic sw_trig; // software trigger write
  logic seq_last; // current channel closes the cycle
  logic seq_end; // cycle completes in this cycle
  logic [2:0] nc; // next channel decode
  logic [STAT_W-1:0] ev; // events of this cycle

  // combinational next state
  always_comb
  begin
    r_next = r_reg;
    r_next.awready = 1'b0;
    r_next.wready = 1'b0;
    r_next.arready = 1'b0;
    r_next.conv_req = 1'b0;
    ev = '0;
    // synchronisers for the pin inputs
    r_next.trig_s1 = ext_trig;
    r_next.trig_s2 = r_reg.trig_s1;
    r_next.trig_d = r_reg.trig_s2;
    r_next.link_s1 = link_clk;
    r_next.link_s2 = r_reg.link_s1;
    r_next.link_d = r_reg.link_s2;
    sw_trig = r_reg.awready && s_axi_awaddr == OFF_TRIG && s_axi_wstrb[0] && s_axi_wdata[TRIG_GO];
    trig_evt = (r_reg.trig_s2 && !r_reg.trig_d) || sw_trig;
    nc = next_chan(r_reg.chan, r_reg.ctrl[CTRL_Z_EN], r_reg.ctrl[CTRL_TEMP_EN]);
    seq_last = nc[2];
    seq_end = r_reg.seq == SEQ_WAIT && conv_done && seq_last;
    mem.wr_en = 1'b0;
    mem.wr_addr = r_reg.chan;
    mem.wr_data = conv_data; // RULE14
    mem.rd_addr = s_axi_araddr[3:2];
    // write channel: address and data taken together
    if (!r_reg.awready && !r_reg.bvalid && s_axi_awvalid && s_axi_wvalid)
    begin
      r_next.awready = 1'b1;
      r_next.wready = 1'b1;
    end
    if (r_reg.awready)
    begin
      r_next.bvalid = 1'b1;
      r_next.bresp = RESP_OKAY;
      case (s_axi_awaddr)
        OFF_CTRL: if (s_axi_wstrb[0]) r_next.ctrl = s_axi_wdata[CTRL_W-1:0];
        OFF_MASK: if (s_axi_wstrb[0]) r_next.mask = s_axi_wdata[STAT_W-1:0];
        OFF_TRIG: r_next.bresp = RESP_OKAY;
        default: r_next.bresp = RESP_SLVERR;
      endcase
    end
    if (r_reg.bvalid && s_axi_bready)
    begin
      r_next.bvalid = 1'b0;
    end
    // read channel: register mux now, result store one cycle later
    if (!r_reg.arready && !r_reg.pend && !r_reg.rvalid && s_axi_arvalid)
    begin
      r_next.arready = 1'b1;
    end
    if (r_reg.arready)
    begin
      r_next.pend = 1'b1;
      r_next.rsel_mem = is_result(s_axi_araddr);
      r_next.rresp = RESP_OKAY;
      r_next.rdata = '0;
      case (s_axi_araddr)
        OFF_CTRL: r_next.rdata[CTRL_W-1:0] = r_reg.ctrl;
        OFF_TRIG: r_next.rdata[8] = r_reg.seq != SEQ_IDLE;
        OFF_STAT:
        begin
          r_next.rdata[STAT_W-1:0] = r_reg.stat;
          r_next.stat = '0; // read clears, events below still win
        end
        OFF_MASK: r_next.rdata[STAT_W-1:0] = r_reg.mask;
        default: if (!is_result(s_axi_araddr)) r_next.rresp = RESP_SLVERR;
      endcase
    end
    if (r_reg.pend)
    begin
      r_next.pend = 1'b0;
      r_next.rvalid = 1'b1;
      if (r_reg.rsel_mem)
      begin
        r_next.rdata = {{(32-SAMPLE_W){mem.rd_data[SAMPLE_W-1]}}, mem.rd_data}; // RULE14
      end
    end
    if (r_reg.rvalid && s_axi_rready)
    begin
      r_next.rvalid = 1'b0;
    end
    // end-of-conversion pulse timing, then arm the first read window
    if (!r_reg.int_n)
    begin
      if (r_reg.int_cnt == '0)
      begin
        r_next.int_n = 1'b1; // RULE1
        r_next.win_arm = 1'b1;
        r_next.win_cnt = r_reg.ctrl[CTRL_SHORT_RANGE] ? WIN_W'(WIN_SR_CYC - 1) : WIN_W'(WIN_CYC - 1);
      end
      else
      begin
        r_next.int_cnt = r_reg.int_cnt - 1'b1;
      end
    end
    // first read window: any link clock rise counts as the host reading
    if (r_reg.win_arm)
    begin
      if (r_reg.link_s2 && !r_reg.link_d)
      begin
        r_next.win_arm = 1'b0;
      end
      else if (r_reg.win_cnt == '0)
      begin
        r_next.win_arm = 1'b0;
        ev[STAT_LATE] = 1'b1;
      end
      else
      begin
        r_next.win_cnt = r_reg.win_cnt - 1'b1;
      end
    end
    // conversion sequencer
    case (r_reg.seq)
      SEQ_IDLE:
      begin
        if (r_reg.ctrl[CTRL_FAST] || trig_evt) // RULE8
        begin
          r_next.seq = SEQ_CONV;
          r_next.chan = CH_X; // RULE16
        end
      end
      SEQ_CONV:
      begin
        r_next.conv_req = 1'b1;
        r_next.conv_chan = r_reg.chan;
        r_next.seq = SEQ_WAIT;
      end
      SEQ_WAIT:
      begin
        if (conv_done)
        begin
          mem.wr_en = 1'b1;
          r_next.chan = nc[1:0]; // RULE16
          if (seq_last)
          begin
            ev[STAT_DONE] = 1'b1;
            r_next.seq = r_reg.ctrl[CTRL_FAST] ? SEQ_CONV : SEQ_IDLE; // RULE7
            if (r_reg.ctrl[CTRL_INT_EN]) // RULE17
            begin
              r_next.int_n = 1'b0; // RULE1
              r_next.int_cnt = PULSE_W'(INT_CYC - 1);
              r_next.win_arm = 1'b0;
            end
          end
          else
          begin
            r_next.seq = SEQ_CONV;
          end
        end
      end
      default: r_next.seq = SEQ_IDLE;
    endcase
    r_next.stat = r_next.stat | ev;
    r_next.irq = |(r_next.stat & r_next.mask);
  end

  // state register with synchronous reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r_reg <= '0;
      r_reg.seq <= SEQ_IDLE;
      r_reg.int_n <= 1'b1;
      r_reg.ctrl <= CTRL_RST; // RULE15
      // link clock idles high, so its history starts high and no false rise follows reset
      r_reg.link_s1 <= 1'b1;
      r_reg.link_s2 <= 1'b1;
      r_reg.link_d <= 1'b1;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // result store
  mcrs_result_mem u_mem (
    .aclk(aclk),
    .aresetn(aresetn),
    .m(mem)
  );

  // outputs straight from the state register
  assign s_axi_awready = r_reg.awready;
  assign s_axi_wready = r_reg.wready;
  assign s_axi_bvalid = r_reg.bvalid;
  assign s_axi_bresp = r_reg.bresp;
  assign s_axi_arready = r_reg.arready;
  assign s_axi_rvalid = r_reg.rvalid;
  assign s_axi_rresp = r_reg.rresp;
  assign s_axi_rdata = r_reg.rdata;
  assign conv_req = r_reg.conv_req;
  assign conv_chan = r_reg.conv_chan;
  assign int_n = r_reg.int_n;
  assign irq = r_reg.irq;

  // helper: length of the current low pulse
  logic [PULSE_W-1:0] low_len;
  always_ff @(posedge aclk)
  begin
    if (!aresetn || int_n)
    begin
      low_len <= '0;
    end
    else
    begin
      low_len <= low_len + 1'b1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_int_width: assert property ($rose(int_n) |-> low_len == PULSE_W'(INT_CYC)) // RULE1
    else $error("end-of-conversion pulse has wrong length");
  chk_int_enabled: assert property ($fell(int_n) |-> $past(r_reg.ctrl[CTRL_INT_EN])) // RULE17
    else $error("pulse while disabled");
  chk_int_per_cycle: assert property ($fell(int_n) |-> $past(seq_end)) // RULE17
    else $error("pulse without a completed cycle");
  chk_fast_restart: assert property (seq_end && r_reg.ctrl[CTRL_FAST] |=> r_reg.seq == SEQ_CONV ##1 conv_req) // RULE7
    else $error("fast mode did not restart");
  chk_idle_trigger: assert property (r_reg.seq == SEQ_IDLE && !r_reg.ctrl[CTRL_FAST] && !trig_evt |=> r_reg.seq == SEQ_IDLE) // RULE8
    else $error("cycle started without trigger");
  chk_end_temp: assert property (r_reg.seq == SEQ_WAIT && conv_done && r_reg.chan == CH_T |-> seq_end) // RULE9
    else $error("cycle did not end after temperature");
  chk_end_z: assert property (r_reg.seq == SEQ_WAIT && conv_done && r_reg.chan == CH_Z && !r_reg.ctrl[CTRL_TEMP_EN] |-> seq_end) // RULE10
    else $error("cycle did not end after z");
  chk_end_y: assert property (r_reg.seq == SEQ_WAIT && conv_done && r_reg.chan == CH_Y && !r_reg.ctrl[CTRL_Z_EN] |-> seq_end) // RULE11
    else $error("cycle did not end after y");
  chk_chan_order: assert property (r_reg.seq == SEQ_WAIT && conv_done && !seq_last |=> ##1 conv_chan == 2'($past(r_reg.chan, 2) + 2'h1)) // RULE16
    else $error("channel order broken");
  chk_temp_reset: assert property (!$past(aresetn) |-> r_reg.ctrl[CTRL_TEMP_EN]) // RULE15
    else $error("temperature disabled after reset");
  chk_sign_ext: assert property (r_reg.pend && r_reg.rsel_mem |=> s_axi_rdata[31:SAMPLE_W] == {(32-SAMPLE_W){s_axi_rdata[SAMPLE_W-1]}}) // RULE14
    else $error("sample not sign extended");

  cov_fast_loop: cover property (seq_end && r_reg.ctrl[CTRL_FAST]);
  cov_triggered: cover property (r_reg.seq == SEQ_IDLE && trig_evt);
  cov_late_read: cover property (ev[STAT_LATE]);
  cov_xy_end: cover property (seq_end && r_reg.chan == CH_Y);

endmodule
`default_nettype wire

// >>> measurement_cycle_readout_sequencer_test.sv
// self-checking bench of the measurement cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module measurement_cycle_readout_sequencer_test
  import mcrs_pkg::*;
;
  localparam int INT_T = 8; // shortened pulse length
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, conv_req, int_n, irq, link_clk;
  logic [1:0] bresp, rresp, conv_chan, rs;
  logic [31:0] rdata;
  logic ext_trig = 1'b0, slow = 1'b0, conv_done = 1'b0;
  logic [SAMPLE_W-1:0] conv_data = '0;
  logic [3:0] gen = 4'hf; // marks which cycle produced a sample
  logic [1:0] chan_q[$]; // channels requested, in order
  int wait_cnt = 0, pulses = 0, low_run = 0, last_low = 0, cyc = 0;
  logic prev_int_n = 1'b1;
  int bad_count = 0, checks_done = 0;

  // clock of 25 ns
  always #12.5 aclk = ~aclk;

  mcrs_seq #(.INT_CYC(INT_T), .WIN_CYC(50), .WIN_SR_CYC(70)) uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_trig(ext_trig),
    .link_clk(link_clk), .conv_req(conv_req), .conv_chan(conv_chan), .conv_done(conv_done),
    .conv_data(conv_data), .int_n(int_n), .irq(irq));

  mcrs_host_model host (.aclk(aclk), .int_n(int_n), .slow(slow), .link_clk(link_clk));

  // converter: logs each request and answers three cycles later
  always @(posedge aclk)
  begin
    conv_done <= 1'b0;
    if (conv_req === 1'b1)
    begin
      chan_q.push_back(conv_chan);
      wait_cnt <= 3;
    end
    else if (wait_cnt == 1)
    begin
      conv_done <= 1'b1;
      conv_data <= {gen, 6'h03, conv_chan};
      wait_cnt <= 0;
    end
    else if (wait_cnt != 0)
      wait_cnt <= wait_cnt - 1;
  end

  // pulse watcher: counts falls and the low length of the last pulse
  always @(posedge aclk)
  begin
    if (int_n === 1'b0)
      low_run <= low_run + 1;
    else if (low_run != 0)
    begin
      last_low <= low_run;
      low_run <= 0;
    end
    if (int_n === 1'b0 && prev_int_n === 1'b1)
      pulses <= pulses + 1;
    prev_int_n <= int_n;
  end

  // hang guard
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      checks_done++;
      if (seen !== exp)
      begin
        bad_count++;
        $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // waits for the answer; only the hang guard ends a stuck wait
      do
      begin
        @(posedge aclk);
        if (awready === 1'b1) awvalid <= 1'b0;
        if (wready === 1'b1) wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
      @(posedge aclk);
    end
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
        @(posedge aclk);
        if (arready === 1'b1) arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge aclk);
    end
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    begin
      axi_read(a, d, rs);
      check(d, exp);
      check(rs, RESP_OKAY);
    end
  endtask

  // polls the busy flag until the cycle has ended
  task automatic wait_idle;
    logic [31:0] d;
    begin
      do
      begin
        axi_read(OFF_TRIG, d, rs);
      end
      while (d[8] !== 1'b0);
    end
  endtask

  // one software-triggered cycle, then time for the read window to close
  task automatic run_cycle(input logic [4:0] cfg);
    begin
      axi_write(OFF_CTRL, {27'h0, cfg}, rs);
      chan_q.delete();
      pulses <= 0;
      axi_write(OFF_TRIG, 32'h1, rs);
      check(rs, RESP_OKAY);
      wait_idle();
      repeat (100) @(posedge aclk);
    end
  endtask

  task automatic report_and_stop;
    begin
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  // main sequence
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    logic [4:0] cfgs[3];
    int n;
    cfgs = '{5'h16, 5'h14, 5'h10};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_check(OFF_CTRL, 32'h16);
    rd_check(OFF_STAT, 32'h0);
    check(int_n, 1'b1);
    check(irq, 1'b0);
    repeat (40) @(posedge aclk);
    check(chan_q.size(), 0);
    $display("test reset done");
    axi_write(OFF_MASK, 32'h1, rs);
    rd_check(OFF_MASK, 32'h1);
    // four, three and two channel sets
    for (int i = 0; i < 3; i++)
    begin
      gen = 4'hf - 4'(i);
      run_cycle(cfgs[i]);
      check(chan_q.size(), 4 - i);
      for (int k = 0; k < chan_q.size(); k++) check(chan_q[k], k);
      check(pulses, 1);
      check(last_low, INT_T);
      check(irq, 1'b1);
      rd_check(OFF_STAT, 32'h1);
      repeat (2) @(posedge aclk);
      check(irq, 1'b0);
      rd_check(OFF_RES_BASE, {20'hfffff, gen, 8'h0c});
      rd_check(OFF_RES_BASE + 8'h04, {20'hfffff, gen, 8'h0d});
    end
    rd_check(OFF_RES_BASE + 8'h0c, 32'hffffff0f);
    rd_check(OFF_RES_BASE + 8'h08, 32'hfffffe0e);
    $display("test channel sets done");
    run_cycle(5'h06);
    check(pulses, 0);
    check(chan_q.size(), 4);
    rd_check(OFF_STAT, 32'h1);
    $display("test pulse disabled done");
    // late host: outside the full range window, inside the short range one
    slow <= 1'b1;
    run_cycle(5'h16);
    rd_check(OFF_STAT, 32'h3);
    run_cycle(5'h1e);
    rd_check(OFF_STAT, 32'h1);
    slow <= 1'b0;
    $display("test read windows done");
    axi_write(OFF_CTRL, 32'h14, rs);
    chan_q.delete();
    ext_trig <= 1'b1;
    repeat (4) @(posedge aclk);
    ext_trig <= 1'b0;
    repeat (6) @(posedge aclk);
    wait_idle();
    check(chan_q.size(), 3);
    $display("test pin trigger done");
    // fast mode restarts without any trigger
    axi_write(OFF_CTRL, 32'h17, rs);
    chan_q.delete();
    pulses <= 0;
    n = 0;
    while (chan_q.size() < 9 && n < 2000)
    begin
      @(posedge aclk);
      n++;
    end
    check(chan_q.size() >= 9, 1'b1);
    check(chan_q[4], CH_X);
    check(pulses >= 2, 1'b1);
    axi_write(OFF_CTRL, 32'h16, rs);
    wait_idle();
    $display("test fast mode done");
    axi_read(8'h40, d, r);
    check(r, RESP_SLVERR);
    check(d, 32'h0);
    axi_write(8'h40, 32'h1, r);
    check(r, RESP_SLVERR);
    $display("test unmapped done");
    report_and_stop();
  end
endmodule
`default_nettype wire
